// *** core/ifs_top.sv ***
/*
  Interrupt enable and request flag registers with the digital control of
  the supply monitor, reached through a byte-wide data memory port.
  Assumes all inputs synchronous to core_clk_in; the analog comparator and
  the core's vectoring logic sit outside.
*/
// Overview of operation
// - three-bit code picks one of eight trip levels
// - status flag high while supply below trip level
// - enable bit powers detector on, clear powers off
// - status read-only; bits 7, 6, 3 read zero
// - sleep mode forces the detector off
// - monitor flag set after fixed delay from status
// - monitor flag rising wakes device from idle
// - four primary, two shared, one edge register
// - each source has own enable and flag
// - two external pins plus internal request sources
// - pin 1 edge field: off, rise, fall, both
// - pin 0 edge field same; bits 7..4 zero
// - flag interrupts only when its enable set
// - global enable clear blocks every interrupt
// - servicing clears global enable, flags still latch
`timescale 1ns/1ns
`default_nettype none
module ifs_top #(
  parameter int DELAY_CYC = ifs_pkg::DETECT_DELAY_CYC
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_in,
  input  wire logic [ifs_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic                       reg_wr_in,
  input  wire logic [7:0]                 reg_wdata_in,
  input  wire logic                       reg_rd_in,
  input  wire logic                       ext_irq_pin_0_in,
  input  wire logic                       ext_irq_pin_1_in,
  input  wire logic [47:0]                src_req_in,
  input  wire logic                       low_supply_cmp_in,
  input  wire logic                       sleep_in,
  input  wire logic                       idle_in,
  input  wire logic                       irq_ack_in,
  output logic [7:0]                      reg_rdata_out,
  output logic                            monitor_on_out,
  output logic [2:0]                      trip_level_select_out,
  output logic                            irq_pending_out,
  output logic                            idle_wake_out
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0]             ctrl_reg [0:ifs_pkg::NUM_CTRL-1];
  logic [7:0]             ctrl_next [0:ifs_pkg::NUM_CTRL-1];
  logic [2:0]             trip_level_reg;
  logic                   monitor_enable_reg;
  logic                   monitor_on_reg;
  logic                   low_supply_status_reg;
  logic [3:0]             edge_sel_reg;
  logic [15:0]            delay_cnt_reg;
  ifs_pkg::ifs_mon_state_t mon_state_reg;
  logic [47:0]            int_set;
  logic                   pin0_edge;
  logic                   pin1_edge;
  logic                   mon_flag_hw;
  logic                   mf0_any;
  logic                   mf1_any;
  logic                   pend_any;

  function automatic logic addr_hit(input logic [3:0] addr,
                                    input logic [3:0] idx);
    addr_hit = (addr == idx);
  endfunction

  // ****************************************************************
  // external pins
  // ****************************************************************
  ifs_edge_det u_pin0 (
    .clk_in   (core_clk_in),
    .rst_in   (rst_in),
    .pin_in   (ext_irq_pin_0_in),
    .mode_in  (edge_sel_reg[1:0]),
    .edge_out (pin0_edge)
  );

  ifs_edge_det u_pin1 (
    .clk_in   (core_clk_in),
    .rst_in   (rst_in),
    .pin_in   (ext_irq_pin_1_in),
    .mode_in  (edge_sel_reg[3:2]),
    .edge_out (pin1_edge)
  );

  // ****************************************************************
  // request flags and enables
  // ****************************************************************
  assign mf0_any = |(ctrl_reg[4][7:4] & ctrl_reg[4][3:0]);
  assign mf1_any = |(ctrl_reg[5][7:4] & ctrl_reg[5][3:0]);

  // internal sources: pins, shared vectors and the monitor
  always_comb begin
    int_set = 48'h0;
    int_set[ifs_pkg::BIT_PIN0_FLAG] = pin0_edge;
    int_set[ifs_pkg::BIT_MF0_FLAG] = mf0_any;
    int_set[8 + ifs_pkg::BIT_MF1_FLAG] = mf1_any;
    int_set[16 + ifs_pkg::BIT_PIN1_FLAG] = pin1_edge;
    int_set[16 + ifs_pkg::BIT_MON_FLAG] = mon_flag_hw;
  end

  generate
    for (genvar g = 0; g < ifs_pkg::NUM_CTRL; g++) begin : g_ctrl
      logic [7:0] hw_set;
      logic [7:0] base;
      logic       hit;
      assign hit = reg_wr_in && addr_hit(reg_addr_in, 4'(g));
      assign hw_set = (src_req_in[g*8 +: 8]
                       & ifs_pkg::EXT_SRC_MASK[g*8 +: 8])
                      | int_set[g*8 +: 8];
      assign base = hit ? reg_wdata_in : ctrl_reg[g];

      // set wins over a write of zero
      always_comb begin
        ctrl_next[g] = (base | hw_set) & ifs_pkg::IMPL_MASK[g*8 +: 8];
        if (g == 0 && irq_ack_in) begin
          ctrl_next[g][ifs_pkg::BIT_GLOBAL_EN] = 1'b0;
        end
      end

      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl_reg[g] <= ifs_pkg::REG_RESET;
        end else begin
          ctrl_reg[g] <= ctrl_next[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // interrupt request to the core
  // ****************************************************************
  assign pend_any = (|(ctrl_reg[0][6:4] & ctrl_reg[0][3:1]))
                  | (|(ctrl_reg[1][7:4] & ctrl_reg[1][3:0]))
                  | (|(ctrl_reg[2][7:4] & ctrl_reg[2][3:0]))
                  | (|(ctrl_reg[3][7:4] & ctrl_reg[3][3:0]));

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_pending_out <= 1'b0;
    end else begin
      irq_pending_out <= ctrl_next[0][ifs_pkg::BIT_GLOBAL_EN]
                         & pend_any & ~irq_ack_in;
    end
  end

  // ****************************************************************
  // edge select and monitor control registers
  // ****************************************************************
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      edge_sel_reg <= 4'h0;
    end else if (reg_wr_in
                 && addr_hit(reg_addr_in, ifs_pkg::IDX_EDGE_SEL)) begin
      edge_sel_reg <= reg_wdata_in[3:0] & ifs_pkg::EDGE_WMASK[3:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trip_level_reg     <= 3'h0;
      monitor_enable_reg <= 1'b0;
    end else if (reg_wr_in
                 && addr_hit(reg_addr_in, ifs_pkg::IDX_MON_CTRL)) begin
      trip_level_reg     <= reg_wdata_in[2:0];
      monitor_enable_reg <= reg_wdata_in[ifs_pkg::BIT_MON_EN];
    end
  end

  assign trip_level_select_out = trip_level_reg;

  // detector power follows enable, forced off in sleep
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      monitor_on_reg <= 1'b0;
    end else begin
      monitor_on_reg <= monitor_enable_reg & ~sleep_in;
    end
  end

  assign monitor_on_out = monitor_on_reg;

  // status reads low from the cycle after the detector is off
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_supply_status_reg <= 1'b0;
    end else begin
      low_supply_status_reg <= monitor_on_reg & low_supply_cmp_in;
    end
  end

  // ****************************************************************
  // detection delay
  // ****************************************************************
  assign mon_flag_hw = (mon_state_reg == ifs_pkg::MON_DELAY) && monitor_on_reg
                    && low_supply_status_reg
                    && (delay_cnt_reg == 16'(DELAY_CYC - 1));
  logic [15:0] low_run_reg;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_run_reg <= 16'h0000;
    end else if (low_supply_status_reg) begin
      low_run_reg <= low_run_reg + 16'h0001;
    end else begin
      low_run_reg <= 16'h0000;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mon_state_reg <= ifs_pkg::MON_OFF;
      delay_cnt_reg <= 16'h0000;
    end else begin
      case (mon_state_reg)
        ifs_pkg::MON_OFF: begin
          if (monitor_on_reg) begin
            mon_state_reg <= ifs_pkg::MON_WATCH;
          end
        end
        ifs_pkg::MON_WATCH: begin
          delay_cnt_reg <= 16'h0000;
          if (!monitor_on_reg) begin
            mon_state_reg <= ifs_pkg::MON_OFF;
          end else if (low_supply_status_reg) begin
            mon_state_reg <= ifs_pkg::MON_DELAY;
          end
        end
        ifs_pkg::MON_DELAY: begin
          if (!monitor_on_reg) begin
            mon_state_reg <= ifs_pkg::MON_OFF;
          end else if (!low_supply_status_reg) begin
            mon_state_reg <= ifs_pkg::MON_WATCH;
          end else if (mon_flag_hw) begin
            mon_state_reg <= ifs_pkg::MON_FIRED;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 16'h0001;
          end
        end
        ifs_pkg::MON_FIRED: begin
          if (!monitor_on_reg) begin
            mon_state_reg <= ifs_pkg::MON_OFF;
          end else if (!low_supply_status_reg) begin
            mon_state_reg <= ifs_pkg::MON_WATCH;
          end
        end
        default: begin
          mon_state_reg <= ifs_pkg::MON_OFF;
        end
      endcase
    end
  end

  // a flag preset by software never rises, so no wake
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_wake_out <= 1'b0;
    end else begin
      idle_wake_out <= idle_in & ~ctrl_reg[2][ifs_pkg::BIT_MON_FLAG]
                       & ctrl_next[2][ifs_pkg::BIT_MON_FLAG];
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_addr_in < 4'(ifs_pkg::NUM_CTRL)) begin
      reg_rdata_out <= ctrl_reg[reg_addr_in[2:0]];
    end else if (addr_hit(reg_addr_in, ifs_pkg::IDX_MON_CTRL)) begin
      reg_rdata_out <= {2'b00, low_supply_status_reg, monitor_enable_reg,
                        1'b0, trip_level_reg};
    end else if (addr_hit(reg_addr_in, ifs_pkg::IDX_EDGE_SEL)) begin
      reg_rdata_out <= {4'h0, edge_sel_reg};
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  mon_read_a: assert property (reg_rd_in &&
      reg_addr_in == ifs_pkg::IDX_MON_CTRL |=>
      reg_rdata_out[7:6] == 2'b00 && !reg_rdata_out[3])
    else $error("monitor reserved bits nonzero");
  sleep_off_a: assert property (sleep_in |=> !monitor_on_out)
    else $error("detector on during sleep");
  mon_on_a: assert property (monitor_enable_reg && !sleep_in
      |=> monitor_on_out) else $error("detector not on");
  status_off_a: assert property (!monitor_on_reg |=>
      !low_supply_status_reg) else $error("status high while off");
  flag_delay_a: assert property (mon_flag_hw |->
      low_run_reg >= 16'(DELAY_CYC)) else $error("monitor flag set early");
  idle_wake_a: assert property ((idle_in &&
      !ctrl_reg[2][ifs_pkg::BIT_MON_FLAG]) ##1
      ctrl_reg[2][ifs_pkg::BIT_MON_FLAG] |-> idle_wake_out)
    else $error("no wake on monitor flag");
  pin0_rise_a: assert property (edge_sel_reg[1:0] == 2'h1 &&
      $rose(ext_irq_pin_0_in) |=> ctrl_reg[0][ifs_pkg::BIT_PIN0_FLAG])
    else $error("pin 0 rise missed");
  pin1_off_a: assert property (edge_sel_reg[3:2] == 2'h0 &&
      !ctrl_reg[2][4] && !reg_wr_in && !src_req_in[20]
      |=> !ctrl_reg[2][4]) else $error("pin 1 flag while off");
  global_block_a: assert property (!ctrl_next[0][0]
      |=> !irq_pending_out) else $error("pending without global");
  ack_clear_a: assert property (irq_ack_in |=> !ctrl_reg[0][0])
    else $error("global enable kept on service");
  flag_hold_a: assert property (ctrl_reg[1][7] && !reg_wr_in
      |=> ctrl_reg[1][7]) else $error("flag lost without write");
  enable_gate_a: assert property (ctrl_reg[3] == 8'h30 &&
      ctrl_reg[0][6:4] == 3'h0 && ctrl_reg[1] == 8'h00 &&
      ctrl_reg[2] == 8'h00 |=> !irq_pending_out)
    else $error("disabled flag interrupts");

  mon_fire_c: cover property (mon_flag_hw);
  pin1_both_c: cover property (edge_sel_reg[3:2] == 2'h3 &&
      $fell(ext_irq_pin_1_in));
  ack_c: cover property (irq_pending_out ##1 irq_ack_in);
  wake_c: cover property (idle_wake_out);

endmodule
`default_nettype wire

// *** pkg/ifs_pkg.sv ***
/*
  Constants for the interrupt flag block and its supply monitor control:
  register indices, bit positions, masks, reset values, edge modes and the
  detection delay.
  Assumes a single 25 MHz core clock and byte-wide register access.
*/
package ifs_pkg;

  // ****************************************************************
  // register indices in the special purpose data memory window
  // ****************************************************************
  localparam int          ADDR_W        = 4;
  localparam int          NUM_CTRL      = 6;
  localparam logic [3:0]  IDX_CTRL0     = 4'h0;
  localparam logic [3:0]  IDX_CTRL1     = 4'h1;
  localparam logic [3:0]  IDX_CTRL2     = 4'h2;
  localparam logic [3:0]  IDX_CTRL3     = 4'h3;
  localparam logic [3:0]  IDX_SHARED0   = 4'h4;
  localparam logic [3:0]  IDX_SHARED1   = 4'h5;
  localparam logic [3:0]  IDX_MON_CTRL  = 4'h6;
  localparam logic [3:0]  IDX_EDGE_SEL  = 4'h7;

  // ****************************************************************
  // per register masks, packed with control 0 in the low byte
  // ****************************************************************
  localparam logic [47:0] IMPL_MASK     = 48'hFF_FF_33_FF_FF_7F;
  localparam logic [47:0] FLAG_MASK     = 48'hF0_F0_30_F0_F0_70;
  localparam logic [47:0] EXT_SRC_MASK  = 48'hF0_F0_30_60_E0_20;
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // ****************************************************************
  // bit positions
  // ****************************************************************
  localparam int          BIT_GLOBAL_EN = 0;
  localparam int          BIT_PIN0_FLAG = 4;
  localparam int          BIT_MF0_FLAG  = 6;
  localparam int          BIT_MF1_FLAG  = 4;
  localparam int          BIT_PIN1_FLAG = 4;
  localparam int          BIT_MON_FLAG  = 7;
  localparam int          BIT_MON_EN    = 4;
  localparam int          BIT_LOW_STAT  = 5;
  localparam logic [7:0]  MON_WMASK     = 8'h17;
  localparam logic [7:0]  EDGE_WMASK    = 8'h0F;

  // ****************************************************************
  // edge modes and monitor states
  // ****************************************************************
  typedef enum logic [1:0] {
    IFS_EDGE_OFF  = 2'h0,
    IFS_EDGE_RISE = 2'h1,
    IFS_EDGE_FALL = 2'h2,
    IFS_EDGE_BOTH = 2'h3
  } ifs_edge_t;

  typedef enum {
    MON_OFF,
    MON_WATCH,
    MON_DELAY,
    MON_FIRED
  } ifs_mon_state_t;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          DETECT_DELAY_NS = 60000;
  localparam int          DETECT_DELAY_CYC =
    (DETECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** core/ifs_edge_det.sv ***
/*
  Edge detector for one external interrupt pin with a two-bit mode.
  Assumes the pin is already synchronous to the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ifs_edge_det (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] mode_in,
  output logic            edge_out
);

  logic pin_prev_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_in;
    end
  end

  always_comb begin
    case (ifs_pkg::ifs_edge_t'(mode_in))
      ifs_pkg::IFS_EDGE_RISE: begin
        edge_out = pin_in & ~pin_prev_reg;
      end
      ifs_pkg::IFS_EDGE_FALL: begin
        edge_out = ~pin_in & pin_prev_reg;
      end
      ifs_pkg::IFS_EDGE_BOTH: begin
        edge_out = pin_in ^ pin_prev_reg;
      end
      default: begin
        edge_out = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** verification/ifs_core_model.sv ***
/*
  Core side model: acknowledges a pending interrupt after a chosen lag.
  Assumes the block's registered pending output and one shared clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ifs_core_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       pending_in,
  input  wire logic       ack_en_in,
  input  wire logic [1:0] lag_in,
  output logic            ack_out
);
  logic [2:0] cnt_reg;
  logic       busy_reg;

  // ****************************************************************
  // service sequence
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg  <= 3'h0;
      busy_reg <= 1'b0;
      ack_out  <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      if (busy_reg) begin
        if (cnt_reg == 3'h0) begin
          ack_out  <= 1'b1;
          busy_reg <= 1'b0;
          // hold-off until the cleared pending level is visible
          cnt_reg  <= 3'h3;
        end else begin
          cnt_reg <= cnt_reg - 3'h1;
        end
      end else if (cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - 3'h1;
      end else if (pending_in && ack_en_in) begin
        busy_reg <= 1'b1;
        cnt_reg  <= {1'b0, lag_in};
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/test_interrupt_flags_with_supply_monitor.sv ***
/*
  Self-checking bench for ifs_top with a core model that acknowledges.
  Assumes the detection delay shortened to 4 cycles and a 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_flags_with_supply_monitor;
  localparam int D = 4;
  logic        clk, rst, wr, rd, pin0, pin1, cmp, slp, idl, ack, ack_en;
  logic        mon_on, pend, wake;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [47:0] src;
  logic [2:0]  trip;
  logic [1:0]  lag;
  logic [31:0] rng;
  logic [7:0]  sh [0:15];
  int          fail_count, checks, acks;
  int          srcs [16] = '{5, 13, 14, 15, 21, 22, 28, 29,
                             36, 37, 38, 39, 44, 45, 46, 47};

  ifs_top #(.DELAY_CYC(D)) dut (
    .core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .ext_irq_pin_0_in(pin0),
    .ext_irq_pin_1_in(pin1), .src_req_in(src), .low_supply_cmp_in(cmp),
    .sleep_in(slp), .idle_in(idl), .irq_ack_in(ack), .reg_rdata_out(rdata),
    .monitor_on_out(mon_on), .trip_level_select_out(trip),
    .irq_pending_out(pend), .idle_wake_out(wake));

  ifs_core_model model (.clk_in(clk), .rst_in(rst), .pending_in(pend),
    .ack_en_in(ack_en), .lag_in(lag), .ack_out(ack));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ack === 1'b1) acks++;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lim(input int n, input int max);
    if (n >= max) begin
      fail_count++;
      $display("MISMATCH t=%0t wait ran out", $time);
      close_out();
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    v = rdata;
    step(1);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_rd(input logic [3:0] a,
                                        input logic [7:0] v);
    if (a < 4'h6) return v & ifs_pkg::IMPL_MASK[int'(a) * 8 +: 8];
    if (a == ifs_pkg::IDX_MON_CTRL) return v & ifs_pkg::MON_WMASK;
    if (a == ifs_pkg::IDX_EDGE_SEL) return v & ifs_pkg::EDGE_WMASK;
    return 8'h00;
  endfunction
  function automatic logic exp_pend();
    return sh[0][0] & (|(sh[0][6:4] & sh[0][3:1])
      | |(sh[1][7:4] & sh[1][3:0]) | |(sh[2][7:4] & sh[2][3:0])
      | |(sh[3][5:4] & sh[3][1:0]));
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] d;
    logic [3:0] a, fr;
    int         n, p, md;
    logic       seen;
    {rst, wr, rd, pin0, pin1, cmp, slp, idl, ack_en} = 9'h100;
    addr = 4'h0;
    wdata = 8'h00;
    src = '0;
    lag = 2'h0;
    rng = 32'h8408;
    for (int i = 0; i < 16; i++) sh[i] = 8'h00;
    step(4);
    rst = 1'b0;
    step(1);
    for (int i = 0; i < 16; i++) begin
      rreg(4'(i), d);
      chk(d, 8'h00);
    end
    for (int i = 0; i < 300; i++) begin
      rng = xs(rng);
      a = (rng[3:0] inside {4'h4, 4'h5, 4'h6}) ? 4'h7 : rng[3:0];
      wreg(a, rng[15:8]);
      sh[a] = exp_rd(a, rng[15:8]);
      a = (rng[19:16] inside {4'h4, 4'h5, 4'h6}) ? 4'h7 : rng[19:16];
      rreg(a, d);
      chk(d, sh[a]);
      chk({7'h0, pend}, {7'h0, exp_pend()});
    end
    for (int i = 7; i >= 0; i--) wreg(4'(i), 8'h00);
    foreach (srcs[k]) begin
      src[srcs[k]] = 1'b1;
      step(1);
      src = '0;
      step(1);
      rreg(4'(srcs[k] / 8), d);
      chk({7'h0, d[srcs[k] % 8]}, 8'h01);
    end
    chk({7'h0, pend}, 8'h00);
    for (int i = 5; i >= 0; i--) begin
      wreg(4'(i), 8'h00);
      rreg(4'(i), d);
      chk(d, 8'h00);
    end
    for (int m = 0; m < 8; m++) begin
      p = m / 4;
      md = m % 4;
      fr = (p == 1) ? 4'h2 : 4'h0;
      wreg(4'h7, 8'(md << (2 * p)));
      for (int lv = 1; lv >= 0; lv--) begin
        pin0 = (p == 0) ? lv[0] : pin0;
        pin1 = (p == 1) ? lv[0] : pin1;
        step(3);
        rreg(fr, d);
        chk(d & 8'h10, (md == 3 || md == 2 - lv) ? 8'h10 : 8'h00);
        wreg(fr, 8'h00);
      end
    end
    wreg(4'h7, 8'h00);
    ack_en = 1'b1;
    lag = rng[1:0];
    wreg(4'h3, 8'h11);
    chk({7'h0, pend}, 8'h00);
    wreg(4'h0, 8'h01);
    n = 0;
    while (acks == 0 && n < 20) begin
      step(1);
      n++;
    end
    lim(n, 20);
    step(2);
    rreg(4'h0, d);
    chk(d, 8'h00);
    src[29] = 1'b1;
    step(1);
    src = '0;
    rreg(4'h3, d);
    chk(d, 8'h31);
    ack_en = 1'b0;
    wreg(4'h3, 8'h30);
    wreg(4'h0, 8'h01);
    step(2);
    chk({7'h0, pend}, 8'h00);
    wreg(4'h0, 8'h00);
    for (int l = 0; l < 8; l++) begin
      wreg(4'h6, 8'hF8 | 8'(l));
      chk({5'h0, trip}, 8'(l));
      chk({7'h0, mon_on}, 8'h01);
      rreg(4'h6, d);
      chk(d, 8'h10 | 8'(l));
    end
    idl = 1'b1;
    step(4);
    cmp = 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < D + 10) begin
      step(1);
      n++;
    end
    lim(n, D + 10);
    chk(8'(n >= D + 1 && n <= D + 3), 8'h01);
    chk({7'h0, wake}, 8'h01);
    rreg(4'h6, d);
    chk(d, 8'h37);
    rreg(4'h2, d);
    chk(d & 8'h80, 8'h80);
    cmp = 1'b0;
    idl = 1'b0;
    wreg(4'h2, 8'h00);
    wreg(4'h2, 8'h80);
    idl = 1'b1;
    cmp = 1'b1;
    seen = 1'b0;
    repeat (D + 8) begin
      step(1);
      seen = seen | (wake === 1'b1);
    end
    chk({7'h0, seen}, 8'h00);
    slp = 1'b1;
    step(2);
    chk({7'h0, mon_on}, 8'h00);
    slp = 1'b0;
    step(2);
    chk({7'h0, mon_on}, 8'h01);
    wreg(4'h6, 8'h00);
    chk({7'h0, mon_on}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
